// [geometry_stage_decode.sv]
// Field extraction from the staged descriptor words
`timescale 1ns/1ps
`default_nettype none
module geometry_stage_decode (
   // Staged descriptor words
   input wire logic [31:0] desc_w4,
   input wire logic [31:0] desc_w5,
   input wire logic [31:0] state_base,
   // Decoded fields
   output logic [4:0] threads_m1,
   output logic [4:0] alloc_code,
   output logic [6:0] entry_count,
   output logic [31:0] sampler_addr,
   output logic resv_bad
);
   logic [26:0] sampler_ptr; // Offset in 32-byte granules

   // Plain slices, plus the sampler address sum and the reserved-bit check done here
   always_comb begin
      threads_m1 = desc_w4[geometry_stage_pkg::THR_MSB:geometry_stage_pkg::THR_LSB];
      alloc_code = desc_w4[geometry_stage_pkg::ALLOC_MSB:geometry_stage_pkg::ALLOC_LSB];
      entry_count = desc_w4[geometry_stage_pkg::COUNT_MSB:geometry_stage_pkg::COUNT_LSB];
      sampler_ptr = desc_w5[geometry_stage_pkg::PTR_MSB:geometry_stage_pkg::PTR_LSB];
      // Granule offset added to the general state base
      sampler_addr = state_base + {sampler_ptr, 5'h00}; // see R11
      resv_bad = |(desc_w4 & geometry_stage_pkg::RESV_MASK);
   end
endmodule : geometry_stage_decode
`default_nettype wire

// [geometry_stage_pkg.sv]
// Constants, field layout and helpers for the geometry stage state decode
`default_nettype none
package geometry_stage_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_DESC_W4 = 8'h00;
   localparam logic [7:0] ADDR_DESC_W5 = 8'h04;
   localparam logic [7:0] ADDR_STATE_BASE = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_SAMPLER = 8'h14;
   // Descriptor word 4 field positions
   localparam int THR_MSB = 29;
   localparam int THR_LSB = 25;
   localparam int ALLOC_MSB = 23;
   localparam int ALLOC_LSB = 19;
   localparam int COUNT_MSB = 17;
   localparam int COUNT_LSB = 11;
   // Bits 18, 10:9, 8 and 7:0 must be zero
   localparam logic [31:0] RESV_MASK = 32'h0004_07FF;
   // Descriptor word 5: sampler pointer, 32-byte granules
   localparam int PTR_MSB = 31;
   localparam int PTR_LSB = 5;
   localparam int GRANULE_SHIFT = 5;
   // Legal entry counts while the stage is enabled
   localparam logic [6:0] COUNT_MIN = 7'h01;
   localparam logic [6:0] COUNT_MAX = 7'h20;
   // Thread field value that means two threads
   localparam logic [4:0] DUAL_THREADS_M1 = 5'h01;
   // Control register bits
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_LOAD = 1;
   localparam int CTRL_FENCE = 2;
   // Status register layout
   localparam int ST_PEND = 0;
   localparam int ST_ERR = 1;
   localparam int ST_DUAL = 2;
   localparam int ST_ENT_LSB = 8;
   localparam int ST_ROWS_LSB = 16;
   // Reset values and bus responses
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Fence tracking states, one-hot
   typedef enum logic [1:0] {FENCE_IDLE = 2'b01, FENCE_WAIT = 2'b10} fence_e;

   // Allocation code to 512-bit units
   function automatic logic [5:0] units_of(input logic [4:0] code);
      units_of = {1'b0, code} + 6'h01;
   endfunction : units_of

   // Allocation code to 256-bit rows, two per unit
   function automatic logic [6:0] rows_of(input logic [4:0] code);
      rows_of = {units_of(code), 1'b0};
   endfunction : rows_of

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = din[i*8 +: 8];
         end
      end
   endfunction : merge
endpackage : geometry_stage_pkg
`default_nettype wire

// [geometry_stage_state_decode.sv]
// Geometry stage descriptor decode with AXI4-Lite register access
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Allocation size field sizes every owned entry
// R2: Codes 0..31 give 2..64 rows
// R3: Size and count change only after fence
// R4: Entry count is seven-bit plain count
// R5: Count 1..32 when enabled, else ignored
// R6: Dual thread: even count, half each
// R7: Software writes zero to reserved bits
// R8: Sampler pointer counts 32-byte granules
// R9: Sampler state stays below 4G boundary; the sampler_addr sum wraps and is not flagged
// R10: Thread field value one means dual
// R11: Sampler address is base plus pointer<<5
module geometry_stage_state_decode (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // Write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address channel
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // Read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Decoded state for dispatch and entry store allocator
   output logic stage_enable,
   output logic dual_thread,
   output logic [5:0] entry_units,
   output logic [6:0] entry_rows,
   output logic [6:0] entry_count,
   output logic [6:0] thread_entries,
   output logic [31:0] sampler_addr,
   output logic fence_pending,
   output logic config_error
);
   // Staged descriptor words, written by software
   logic [31:0] desc_w4, next_desc_w4;
   logic [31:0] desc_w5, next_desc_w5;
   logic [31:0] state_base, next_state_base;
   logic next_stage_enable;
   // Active state taken at load
   logic [4:0] act_threads_m1, next_act_threads_m1;
   logic [31:0] next_sampler_addr;
   logic next_dual_thread;
   // Pending size and count, waiting for the fence
   logic [4:0] pend_alloc, next_pend_alloc;
   logic [6:0] pend_count, next_pend_count;
   logic [4:0] act_alloc, next_act_alloc;
   logic [6:0] act_count, next_act_count;
   logic act_resv, next_act_resv;
   geometry_stage_pkg::fence_e fence_state, next_fence_state;
   // Bus response state
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   // Decoder outputs
   logic [4:0] dec_threads_m1;
   logic [4:0] dec_alloc;
   logic [6:0] dec_count;
   logic [31:0] dec_sampler_addr;
   logic dec_resv;
   // Handshake terms
   logic wr_go, rd_go, load_go, fence_go;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] ctrl_word;

   geometry_stage_decode u_decode (
      .desc_w4(desc_w4),
      .desc_w5(desc_w5),
      .state_base(state_base),
      .threads_m1(dec_threads_m1),
      .alloc_code(dec_alloc),
      .entry_count(dec_count),
      .sampler_addr(dec_sampler_addr),
      .resv_bad(dec_resv)
   );

   // Write taken only with both address and data; one write in flight
   assign wr_go = awvalid && wvalid && !bvalid;
   assign awready = wr_go;
   assign wready = wr_go;
   assign rd_go = arvalid && !rvalid;
   assign arready = !rvalid;
   assign wr_addr = {awaddr[7:2], 2'h0};
   assign rd_addr = {araddr[7:2], 2'h0};
   assign ctrl_word = geometry_stage_pkg::merge(geometry_stage_pkg::WORD_RESET, wdata, wstrb);
   // Load and fence are write-one pulses in the control register
   assign load_go = wr_go && wr_addr == geometry_stage_pkg::ADDR_CTRL
                    && ctrl_word[geometry_stage_pkg::CTRL_LOAD];
   assign fence_go = wr_go && wr_addr == geometry_stage_pkg::ADDR_CTRL
                     && ctrl_word[geometry_stage_pkg::CTRL_FENCE];

   // Register writes, load and fence
   always_comb begin
      next_desc_w4 = desc_w4;
      next_desc_w5 = desc_w5;
      next_state_base = state_base;
      next_stage_enable = stage_enable;
      next_act_threads_m1 = act_threads_m1;
      next_sampler_addr = sampler_addr;
      next_dual_thread = dual_thread;
      next_pend_alloc = pend_alloc;
      next_pend_count = pend_count;
      next_act_alloc = act_alloc;
      next_act_count = act_count;
      next_act_resv = act_resv;
      next_fence_state = fence_state;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp = geometry_stage_pkg::RESP_OKAY;
         case (wr_addr)
            geometry_stage_pkg::ADDR_DESC_W4:
               next_desc_w4 = geometry_stage_pkg::merge(desc_w4, wdata, wstrb);
            geometry_stage_pkg::ADDR_DESC_W5:
               next_desc_w5 = geometry_stage_pkg::merge(desc_w5, wdata, wstrb);
            geometry_stage_pkg::ADDR_STATE_BASE:
               next_state_base = geometry_stage_pkg::merge(state_base, wdata, wstrb);
            geometry_stage_pkg::ADDR_CTRL:
               next_stage_enable = ctrl_word[geometry_stage_pkg::CTRL_ENABLE];
            // Status and sampler address are read-only
            geometry_stage_pkg::ADDR_STATUS, geometry_stage_pkg::ADDR_SAMPLER:
               next_bresp = geometry_stage_pkg::RESP_OKAY;
            default: next_bresp = geometry_stage_pkg::RESP_SLVERR;
         endcase
      end
      if (load_go) begin
         // Pointer and thread count take effect at once
         next_act_threads_m1 = dec_threads_m1;
         next_dual_thread = dec_threads_m1 == geometry_stage_pkg::DUAL_THREADS_M1; // see R10
         next_sampler_addr = dec_sampler_addr; // see R8
         next_act_resv = dec_resv; // see R7
         // Size and count are parked until the fence arrives
         next_pend_alloc = dec_alloc; // see R1
         next_pend_count = dec_count; // see R4
         if (dec_alloc != act_alloc || dec_count != act_count) begin
            next_fence_state = geometry_stage_pkg::FENCE_WAIT; // see R3
         end
      end
      if (fence_go) begin
         // Fence in the same write as a load applies the new values
         next_act_alloc = next_pend_alloc; // see R3
         next_act_count = next_pend_count; // see R3
         next_fence_state = geometry_stage_pkg::FENCE_IDLE;
      end
      case (fence_state)
         geometry_stage_pkg::FENCE_IDLE, geometry_stage_pkg::FENCE_WAIT: ;
         default: next_fence_state = geometry_stage_pkg::FENCE_IDLE;
      endcase
   end

   // Registers of the write side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         desc_w4 <= geometry_stage_pkg::WORD_RESET;
         desc_w5 <= geometry_stage_pkg::WORD_RESET;
         state_base <= geometry_stage_pkg::WORD_RESET;
         stage_enable <= 1'b0;
         act_threads_m1 <= 5'h00;
         sampler_addr <= geometry_stage_pkg::WORD_RESET;
         dual_thread <= 1'b0;
         pend_alloc <= 5'h00;
         pend_count <= 7'h00;
         act_alloc <= 5'h00;
         act_count <= 7'h00;
         act_resv <= 1'b0;
         fence_state <= geometry_stage_pkg::FENCE_IDLE;
         bvalid <= 1'b0;
         bresp <= geometry_stage_pkg::RESP_OKAY;
      end else begin
         desc_w4 <= next_desc_w4;
         desc_w5 <= next_desc_w5;
         state_base <= next_state_base;
         stage_enable <= next_stage_enable;
         act_threads_m1 <= next_act_threads_m1;
         sampler_addr <= next_sampler_addr;
         dual_thread <= next_dual_thread;
         pend_alloc <= next_pend_alloc;
         pend_count <= next_pend_count;
         act_alloc <= next_act_alloc;
         act_count <= next_act_count;
         act_resv <= next_act_resv;
         fence_state <= next_fence_state;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   // Outputs derived from the fenced values, the state taken at load and the enable
   always_comb begin
      entry_units = geometry_stage_pkg::units_of(act_alloc); // see R1
      entry_rows = geometry_stage_pkg::rows_of(act_alloc); // see R2
      // Count means nothing while the stage is off
      entry_count = stage_enable ? act_count : 7'h00; // see R5
      thread_entries = dual_thread ? {1'b0, entry_count[6:1]} : entry_count; // see R6
      fence_pending = fence_state == geometry_stage_pkg::FENCE_WAIT;
      // Flags programming the device cannot honour
      config_error = stage_enable && (act_count < geometry_stage_pkg::COUNT_MIN
                     || act_count > geometry_stage_pkg::COUNT_MAX
                     || (dual_thread && act_count[0]) || act_resv); // see R5
   end

   // Read mux and response
   always_comb begin
      next_rvalid = rvalid && !rready;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = geometry_stage_pkg::RESP_OKAY;
         next_rdata = geometry_stage_pkg::WORD_RESET;
         case (rd_addr)
            geometry_stage_pkg::ADDR_DESC_W4: next_rdata = desc_w4;
            geometry_stage_pkg::ADDR_DESC_W5: next_rdata = desc_w5;
            geometry_stage_pkg::ADDR_STATE_BASE: next_rdata = state_base;
            geometry_stage_pkg::ADDR_CTRL:
               next_rdata[geometry_stage_pkg::CTRL_ENABLE] = stage_enable;
            geometry_stage_pkg::ADDR_STATUS: begin
               next_rdata[geometry_stage_pkg::ST_PEND] = fence_pending;
               next_rdata[geometry_stage_pkg::ST_ERR] = config_error;
               next_rdata[geometry_stage_pkg::ST_DUAL] = dual_thread;
               next_rdata[geometry_stage_pkg::ST_ENT_LSB +: 7] = thread_entries;
               next_rdata[geometry_stage_pkg::ST_ROWS_LSB +: 7] = entry_rows;
            end
            geometry_stage_pkg::ADDR_SAMPLER: next_rdata = sampler_addr;
            default: next_rresp = geometry_stage_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Registers of the read side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= geometry_stage_pkg::WORD_RESET;
         rresp <= geometry_stage_pkg::RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence load_take;
      load_go && !fence_go;
   endsequence
   sequence fence_take;
      fence_go;
   endsequence

   rows_map_a: assert property (entry_rows == {entry_units, 1'b0} && entry_units != 6'h00) // see R2
      else $error("rows not twice units");
   alloc_apply_a: assert property (fence_take |=> entry_units == $past(next_pend_alloc) + 6'h01) // see R1
      else $error("fence did not apply allocation size");
   hold_fence_a: assert property (!fence_go |=> $stable(act_count) && $stable(act_alloc)) // see R3
      else $error("size or count changed without fence");
   count_take_a: assert property (load_take |=> pend_count == $past(desc_w4[17:11])) // see R4
      else $error("entry count not taken from field");
   count_ignore_a: assert property (!stage_enable |-> thread_entries == 7'h00 && !config_error) // see R5
      else $error("count used while stage disabled");
   half_split_a: assert property (stage_enable && dual_thread && !act_count[0]
                                  |-> {thread_entries, 1'b0} == {1'b0, act_count}) // see R6
      else $error("dual thread split wrong");
   resv_flag_a: assert property (load_go && (desc_w4 & geometry_stage_pkg::RESV_MASK) != 32'h0
                                 ##1 stage_enable |-> config_error) // see R7
      else $error("reserved bits not flagged");
   sampler_addr_a: assert property (load_take |=> sampler_addr == $past(state_base)
                                    + {$past(desc_w5[31:5]), 5'h00}) // see R11
      else $error("sampler address wrong");
   dual_mode_a: assert property (load_take |=> dual_thread == ($past(desc_w4[29:25]) == 5'h01)) // see R10
      else $error("dual thread decode wrong");
   write_resp_a: assert property (wr_go |=> bvalid) // AXI4-Lite handshake, the implementer's own choice
      else $error("write not answered");
endmodule : geometry_stage_state_decode
`default_nettype wire

// [geometry_stage_sw_model.sv]
// Software-side register bus master that writes descriptors into the stage
`timescale 1ns/1ps
`default_nettype none
module geometry_stage_sw_model (
   // Clock
   input wire logic aclk,
   // Write request channels
   output logic [7:0] awaddr,
   output logic [2:0] awprot,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   // Write response
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic [2:0] arprot,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus at time zero
   initial begin
      {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arprot, arvalid, rready} = '0;
   end

   // A wait that never ends is reported and closes the run
   task automatic hang();
      tb.n_mismatch++;
      $display("BAD bus_answer expected response seen none");
      tb.finish_test();
   endtask : hang

   // One write; each channel held until its own ready edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         // Released address and data lines show the inverse, never the last value
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
      if (n == 100) hang();
      bready <= 1'b0;
      // Extra edge so the next request never lands in this time step
      @(posedge aclk);
   endtask : wr

   // One read; address held until taken, data taken at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      if (n == 100) hang();
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
endmodule : geometry_stage_sw_model
`default_nettype wire

// [geometry_stage_tb.sv]
// Self-checking bench for the geometry stage state decode
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module tb;
   // Clock, reset and counters
   logic aclk = 1'b0;
   logic aresetn;
   int n_mismatch = 0;
   int total_checks = 0;
   // Bus wires between model and block
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, sampler_addr;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   // Decoded outputs
   logic stage_enable, dual_thread, fence_pending, config_error;
   logic [5:0] entry_units;
   logic [6:0] entry_rows, entry_count, thread_entries;

   geometry_stage_state_decode dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .stage_enable(stage_enable),
      .dual_thread(dual_thread), .entry_units(entry_units), .entry_rows(entry_rows),
      .entry_count(entry_count), .thread_entries(thread_entries),
      .sampler_addr(sampler_addr), .fence_pending(fence_pending), .config_error(config_error));
   geometry_stage_sw_model drv_u (.aclk(aclk), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end

   // Descriptor word with every reserved bit left at zero
   function automatic logic [31:0] mk4(logic [4:0] thr, logic [4:0] sz, logic [6:0] cnt);
      mk4 = {2'h0, thr, 1'b0, sz, 1'b0, cnt, 11'h000};
   endfunction : mk4

   // Expected status word
   function automatic logic [31:0] st(logic [6:0] rows, logic [6:0] te, logic [2:0] f);
      st = {9'h000, rows, 1'b0, te, 5'h00, f};
   endfunction : st

   // Full-word write expecting OKAY
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      drv_u.wr(a, d, 4'hF, r);
      `CHK("bresp", 2'h0, r)
   endtask : put

   // Read and compare with OKAY expected
   task automatic get(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      drv_u.rd(a, d, r);
      `CHK("rresp", 2'h0, r)
      `CHK("rdata", e, d)
   endtask : get

   // Values straight after reset
   task automatic sc_reset();
      `CHK("units", 6'h01, entry_units)
      `CHK("rows", 7'h02, entry_rows)
      `CHK("count", 7'h00, entry_count)
      get(geometry_stage_pkg::ADDR_STATUS, 32'h0002_0000);
      get(geometry_stage_pkg::ADDR_SAMPLER, 32'h0000_0000);
   endtask : sc_reset

   // Size codes across the range, held back until the fence
   task automatic sc_alloc();
      logic [4:0] codes [4] = '{5'h1F, 5'h00, 5'h10, 5'h01};
      logic [5:0] prev;
      prev = 6'h01;
      foreach (codes[i]) begin
         put(geometry_stage_pkg::ADDR_DESC_W4, mk4(5'h00, codes[i], 7'h04));
         put(geometry_stage_pkg::ADDR_CTRL, 32'h0000_0003);
         `CHK("units_held", prev, entry_units)
         `CHK("pending", 1'b1, fence_pending)
         put(geometry_stage_pkg::ADDR_CTRL, 32'h0000_0005);
         prev = {1'b0, codes[i]} + 6'h01;
         `CHK("units", prev, entry_units)
         get(geometry_stage_pkg::ADDR_STATUS, st({prev, 1'b0}, 7'h04, 3'h0));
      end
   endtask : sc_alloc

   // Sampler address and flagged reserved bits
   task automatic sc_sampler();
      logic [31:0] bad [3] = '{32'h0004_0000, 32'h0000_0400, 32'h0000_0001};
      put(geometry_stage_pkg::ADDR_STATE_BASE, 32'h1234_5000);
      put(geometry_stage_pkg::ADDR_DESC_W5, 32'hABCD_EF43);
      foreach (bad[i]) begin
         put(geometry_stage_pkg::ADDR_DESC_W4, mk4(5'h00, 5'h02, 7'h04) | bad[i]);
         put(geometry_stage_pkg::ADDR_CTRL, 32'h0000_0003);
         `CHK("resv_err", 1'b1, config_error)
      end
      put(geometry_stage_pkg::ADDR_DESC_W4, mk4(5'h00, 5'h02, 7'h04));
      put(geometry_stage_pkg::ADDR_CTRL, 32'h0000_0007);
      `CHK("resv_ok", 1'b0, config_error)
      `CHK("sampler", 32'h1234_5000 + 32'hABCD_EF40, sampler_addr)
      get(geometry_stage_pkg::ADDR_SAMPLER, 32'h1234_5000 + 32'hABCD_EF40);
   endtask : sc_sampler

   // Entry counts, thread modes and enable
   task automatic sc_count();
      logic [12:0] tab [8] = '{{1'b1, 5'h01, 7'd32}, {1'b1, 5'h01, 7'd7}, {1'b1, 5'h00, 7'd1},
         {1'b1, 5'h02, 7'd6}, {1'b1, 5'h00, 7'd0}, {1'b1, 5'h00, 7'd33},
         {1'b1, 5'h00, 7'd127}, {1'b0, 5'h01, 7'd0}};
      logic en, du, er;
      logic [6:0] c;
      foreach (tab[i]) begin
         {en, c} = {tab[i][12], tab[i][6:0]};
         du = (tab[i][11:7] == 5'h01);
         er = en && (c < 7'd1 || c > 7'd32 || (du && c[0]));
         put(geometry_stage_pkg::ADDR_DESC_W4, mk4(tab[i][11:7], 5'h03, c));
         put(geometry_stage_pkg::ADDR_CTRL, {29'h0, 2'h3, en});
         `CHK("enable", en, stage_enable)
         `CHK("dual", du, dual_thread)
         `CHK("count", en ? c : 7'h00, entry_count)
         `CHK("per_thread", en ? (du ? c >> 1 : c) : 7'h00, thread_entries)
         `CHK("cfg_err", er, config_error)
      end
      get(geometry_stage_pkg::ADDR_CTRL, 32'h0000_0000);
   endtask : sc_count

   // Byte lanes, read-only and unmapped places
   task automatic sc_bus();
      logic [31:0] d;
      logic [1:0] r;
      put(geometry_stage_pkg::ADDR_STATE_BASE, 32'hFFFF_FFFF);
      drv_u.wr(geometry_stage_pkg::ADDR_STATE_BASE, 32'h0000_0000, 4'h5, r);
      get(geometry_stage_pkg::ADDR_STATE_BASE, 32'hFF00_FF00);
      put(geometry_stage_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      get(geometry_stage_pkg::ADDR_STATUS, st(7'h08, 7'h00, 3'h4));
      drv_u.wr(8'h18, 32'h1234_5678, 4'hF, r);
      `CHK("unmapped_bresp", 2'h2, r)
      drv_u.rd(8'h18, d, r);
      `CHK("unmapped_rresp", 2'h2, r)
      `CHK("unmapped_rdata", 32'h0000_0000, d)
   endtask : sc_bus

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      sc_reset();
      sc_alloc();
      sc_sampler();
      sc_count();
      sc_bus();
      finish_test();
   end
endmodule : tb
`default_nettype wire
